// ===== hdl/spp_regs.svh
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

// Register byte offsets on the bus
`define SPP_ADR_CTRL      8'h00
`define SPP_ADR_DATA      8'h04
`define SPP_ADR_CLKDIV    8'h08

// Control register field positions
`define SPP_BIT_EN        0
`define SPP_BIT_MASTER_ENABLE_BIT     1
`define SPP_BIT_MODE_LO   2
`define SPP_BIT_MODE_HI   3
`define SPP_BIT_OVRN      4
`define SPP_BIT_MODE_FAULT_FLAG      5
`define SPP_BIT_WCOL      6
`define SPP_BIT_DONE      7

// Reset values
`define SPP_RST_MODE      2'h1
`define SPP_RST_CLKDIV    8'h03

// Select-mode encodings
`define SPP_MODE_3WIRE    2'h0
`define SPP_MODE_4W_IN    2'h1

// Index of the last bit in a transfer
`define SPP_LAST_BIT      3'h7

`endif

// ===== hdl/spp_pkg.sv
package spp_pkg;

    // Master shift engine states
    typedef enum logic {
        SPP_IDLE,
        SPP_RUN
    } spp_state_e;

    typedef logic [7:0] spp_byte_t;

endpackage : spp_pkg

// ===== hdl/spp_port.sv
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "spp_regs.svh"

module spp_port (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Master-out data line
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe,
    // Master-in data line
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe,
    // Serial clock line
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    // Slave select line and its pin routing
    input  wire logic        slave_select_line_i,
    output logic             slave_select_line_o,
    output logic             slave_select_line_oe,
    output logic             select_routed
);
    import spp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic        port_enable_bit_q;
    logic        master_enable_bit_q;
    logic [1:0]  select_mode_field_q;
    logic        transfer_done_flag_q;
    logic        write_coll_flag_q;
    logic        mode_fault_flag_q;
    logic        rx_overrun_flag_q;
    logic [7:0]  clkdiv_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [3:0]  meta_q;
    logic [3:0]  sync_q;
    logic        sck_dly_q;
    logic        ss_dly_q;
    spp_state_e  state_q;
    logic [7:0]  div_cnt_q;
    logic        sck_q;
    spp_byte_t   sh_q;
    logic        samp_q;
    logic [2:0]  cnt_q;
    logic        sh_empty_q;
    spp_byte_t   txbuf_q;
    logic        txfull_q;
    spp_byte_t   rxbuf_q;
    logic        rxfull_q;
    logic        miso_oe_q;
    logic        mosi_oe_q;
    logic        sck_oe_q;
    logic        ss_oe_q;
    logic        ss_o_q;
    logic        routed_q;

    logic        bus_req;
    logic        wr_ctrl;
    logic        wr_data;
    logic        wr_div;
    logic        rd_data;
    logic        ss_s;
    logic        sck_s;
    logic        mosi_s;
    logic        miso_s;
    logic        selected;
    logic        slave_act;
    logic        master_act;
    logic        tick;
    logic        m_sample;
    logic        m_shift;
    logic        s_sample;
    logic        s_shift;
    logic        done_evt;
    logic        mode_fault_evt;
    logic        load_master;
    logic        load_slave;
    spp_byte_t   rx_byte;

    // Byte lane zero write strobe for a given offset
    function automatic logic lane0_wr(input logic [7:0] adr, input logic [7:0] off);
        lane0_wr = bus_req && wb_we_i && wb_sel_i[0] && (adr == off);
    endfunction : lane0_wr

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; one wait state, ack drops the cycle after it rises

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ctrl = lane0_wr(wb_adr_i, `SPP_ADR_CTRL);
    assign wr_data = lane0_wr(wb_adr_i, `SPP_ADR_DATA);
    assign wr_div  = lane0_wr(wb_adr_i, `SPP_ADR_CLKDIV);
    assign rd_data = bus_req && !wb_we_i && (wb_adr_i == `SPP_ADR_DATA);

    // Acknowledge and read data, unmapped reads give zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= 32'h0;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `SPP_ADR_CTRL: begin
                        rdata_q[7:0] <= {transfer_done_flag_q, write_coll_flag_q, mode_fault_flag_q,
                                         rx_overrun_flag_q, select_mode_field_q, master_enable_bit_q,
                                         port_enable_bit_q};
                    end
                    `SPP_ADR_DATA:   rdata_q[7:0] <= rxbuf_q;
                    `SPP_ADR_CLKDIV: rdata_q[7:0] <= clkdiv_q;
                    default:         rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops, third stage only for edge finding

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            meta_q    <= 4'h8;
            sync_q    <= 4'h8;
            sck_dly_q <= 1'b0;
            ss_dly_q  <= 1'b1;
        end else begin
            meta_q    <= {slave_select_line_i, sck_i, mosi_i, miso_i};
            sync_q    <= meta_q;
            sck_dly_q <= sync_q[2];
            ss_dly_q  <= sync_q[3];
        end
    end

    assign ss_s   = sync_q[3];
    assign sck_s  = sync_q[2];
    assign mosi_s = sync_q[1];
    assign miso_s = sync_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Three-wire and select-output modes count as always selected
    assign selected   = (select_mode_field_q != `SPP_MODE_4W_IN) || !ss_s;
    assign master_act = port_enable_bit_q && master_enable_bit_q;
    assign slave_act  = port_enable_bit_q && !master_enable_bit_q && selected;

    // Multi-master: select low while master drops the master function
    assign mode_fault_evt = master_act && (select_mode_field_q == `SPP_MODE_4W_IN) && !ss_s;

    ////////////////////////////////////////////////////////////////////////
    // Control, divider and flag registers; hardware set beats software clear

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            port_enable_bit_q   <= 1'b0;
            master_enable_bit_q <= 1'b0;
            select_mode_field_q <= `SPP_RST_MODE;
            clkdiv_q            <= `SPP_RST_CLKDIV;
        end else begin
            if (wr_ctrl) begin
                port_enable_bit_q   <= wb_dat_i[`SPP_BIT_EN];
                master_enable_bit_q <= wb_dat_i[`SPP_BIT_MASTER_ENABLE_BIT];
                select_mode_field_q <= wb_dat_i[`SPP_BIT_MODE_HI:`SPP_BIT_MODE_LO];
            end
            if (mode_fault_evt) begin
                port_enable_bit_q   <= 1'b0;
                master_enable_bit_q <= 1'b0;
            end
            if (wr_div) begin
                clkdiv_q <= wb_dat_i[7:0];
            end
        end
    end

    // Flags: write 0 clears, write 1 keeps, a new event always sets
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            transfer_done_flag_q <= 1'b0;
            write_coll_flag_q    <= 1'b0;
            mode_fault_flag_q    <= 1'b0;
            rx_overrun_flag_q    <= 1'b0;
        end else begin
            transfer_done_flag_q <= done_evt ||
                (transfer_done_flag_q && !(wr_ctrl && !wb_dat_i[`SPP_BIT_DONE]));
            write_coll_flag_q    <= (wr_data && txfull_q) ||
                (write_coll_flag_q && !(wr_ctrl && !wb_dat_i[`SPP_BIT_WCOL]));
            mode_fault_flag_q    <= mode_fault_evt ||
                (mode_fault_flag_q && !(wr_ctrl && !wb_dat_i[`SPP_BIT_MODE_FAULT_FLAG]));
            rx_overrun_flag_q    <= (done_evt && !master_enable_bit_q && rxfull_q) ||
                (rx_overrun_flag_q && !(wr_ctrl && !wb_dat_i[`SPP_BIT_OVRN]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit and receive buffers

    // A write to a full transmit buffer is dropped
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            txbuf_q  <= 8'h00;
            txfull_q <= 1'b0;
        end else if (wr_data && !txfull_q) begin
            txbuf_q  <= wb_dat_i[7:0];
            txfull_q <= 1'b1;
        end else if (load_master || load_slave) begin
            txfull_q <= 1'b0;
        end
    end

    assign rx_byte = {sh_q[6:0], samp_q};

    // Slave overrun keeps the unread byte; master always replaces it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rxbuf_q  <= 8'h00;
            rxfull_q <= 1'b0;
        end else if (done_evt && (master_enable_bit_q || !rxfull_q)) begin
            rxbuf_q  <= rx_byte;
            rxfull_q <= 1'b1;
        end else if (rd_data) begin
            rxfull_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine: sample on clock rise, shift on clock fall

    // Divider ticks every clkdiv+1 cycles, one tick per half period
    assign tick        = (state_q == SPP_RUN) && (div_cnt_q == clkdiv_q);
    assign m_sample    = tick && !sck_q;
    assign m_shift     = tick && sck_q;
    assign s_sample    = slave_act && sck_s && !sck_dly_q;
    assign s_shift     = slave_act && !sck_s && sck_dly_q;
    assign load_master = master_act && (state_q == SPP_IDLE) && txfull_q && !mode_fault_evt;
    assign load_slave  = slave_act && sh_empty_q && (cnt_q == 3'h0) && txfull_q && !s_shift && (ss_s == ss_dly_q);
    assign done_evt    = (m_shift || s_shift) && (cnt_q == `SPP_LAST_BIT);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q    <= SPP_IDLE;
            div_cnt_q  <= 8'h00;
            sck_q      <= 1'b0;
            sh_q       <= 8'h00;
            samp_q     <= 1'b0;
            cnt_q      <= 3'h0;
            sh_empty_q <= 1'b1;
        end else if (!port_enable_bit_q || (state_q == SPP_RUN && !master_act)) begin
            // Disable resets the bit count, the only way out in three-wire slave
            state_q    <= SPP_IDLE;
            div_cnt_q  <= 8'h00;
            sck_q      <= 1'b0;
            cnt_q      <= 3'h0;
            sh_empty_q <= 1'b1;
        end else begin
            case (state_q)
                SPP_IDLE: begin
                    if (load_master) begin
                        sh_q      <= txbuf_q;
                        state_q   <= SPP_RUN;
                        div_cnt_q <= 8'h00;
                        cnt_q     <= 3'h0;
                    end
                end
                SPP_RUN: begin
                    div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01;
                    if (tick) begin
                        sck_q <= !sck_q;
                    end
                    if (m_sample) begin
                        samp_q <= miso_s;
                    end
                    if (m_shift) begin
                        sh_q  <= rx_byte;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == `SPP_LAST_BIT) begin
                            state_q <= SPP_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= SPP_IDLE;
                end
            endcase
            // Slave side, only ever active while master enable is clear
            if (!master_enable_bit_q) begin
                if (select_mode_field_q == `SPP_MODE_4W_IN && !ss_s && ss_dly_q) begin
                    cnt_q <= 3'h0;
                end else if (s_shift) begin
                    sh_q  <= rx_byte;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == `SPP_LAST_BIT) begin
                        sh_empty_q <= 1'b1;
                    end
                end else if (load_slave) begin
                    sh_q       <= txbuf_q;
                    sh_empty_q <= 1'b0;
                end
                if (s_sample) begin
                    samp_q <= mosi_s;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered; enables lag configuration by one cycle

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            sck_oe_q  <= 1'b0;
            ss_oe_q   <= 1'b0;
            ss_o_q    <= 1'b1;
            routed_q  <= 1'b1;
        end else begin
            mosi_oe_q <= master_act;
            sck_oe_q  <= master_act;
            miso_oe_q <= slave_act;
            ss_oe_q   <= select_mode_field_q[1];
            ss_o_q    <= select_mode_field_q[0];
            routed_q  <= (select_mode_field_q != `SPP_MODE_3WIRE);
        end
    end

    // Data outputs straight from the shift register top bit
    assign mosi_o               = sh_q[7];
    assign miso_o               = sh_q[7];
    assign mosi_oe              = mosi_oe_q;
    assign miso_oe              = miso_oe_q;
    assign sck_o                = sck_q;
    assign sck_oe               = sck_oe_q;
    assign slave_select_line_o  = ss_o_q;
    assign slave_select_line_oe = ss_oe_q;
    assign select_routed        = routed_q;

endmodule : spp_port

// ===== dv/spp_port_props.sv
`timescale 1ns/1ps

module spp_port_props (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Bus side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Serial pins
    input wire logic        mosi_o,
    input wire logic        mosi_oe,
    input wire logic        miso_o,
    input wire logic        miso_oe,
    input wire logic        sck_i,
    input wire logic        sck_o,
    input wire logic        sck_oe,
    input wire logic        slave_select_line_i,
    input wire logic        slave_select_line_oe,
    input wire logic        select_routed
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Pin direction follows the role
    AST_MASTER_PINS: assert property (mosi_oe == sck_oe)
        else $error("master data and clock enables differ");
    AST_SLAVE_PINS: assert property (miso_oe |-> !sck_oe && !mosi_oe)
        else $error("slave output while driving master pins");
    // Five cycles covers the select synchroniser and the enable flop
    AST_MISO_UNSEL: assert property ((slave_select_line_i && select_routed
        && !slave_select_line_oe) [*5] |-> !miso_oe)
        else $error("unselected slave drives its output");
    AST_SS_ROUTED: assert property (slave_select_line_oe |-> select_routed)
        else $error("select driven but not routed");
    AST_MOSI_SETUP: assert property ($rose(sck_o) |=> $stable(mosi_o))
        else $error("master data moved around clock rise");
    AST_MISO_SETUP: assert property ($rose(sck_i) && miso_oe |=> $stable(miso_o))
        else $error("slave data moved around clock rise");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake
    AST_ACK_LAT: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");

    // Main scenarios reached
    cover property ($rose(sck_oe));
    cover property ($rose(miso_oe));
    cover property (wb_ack_o && !select_routed);
endmodule : spp_port_props

bind spp_port spp_port_props u_props (.clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .mosi_o, .mosi_oe, .miso_o, .miso_oe, .sck_i, .sck_o, .sck_oe, .slave_select_line_i,
    .slave_select_line_oe, .select_routed);

// ===== dv/spp_far_slave.sv
`timescale 1ns/1ps

module spp_far_slave
    import spp_pkg::*;
(
    // Link from the port as master
    input  wire logic      sck,
    input  wire logic      sck_en,
    input  wire logic      mosi,
    // Bench control
    input  wire logic      load,
    input  spp_byte_t      tx_byte,
    // Reply and capture
    output logic           miso,
    output logic           miso_en,
    output spp_byte_t      rx_q
);
    spp_byte_t sh_q;
    wire logic sck_g = sck & sck_en;

    // Sample on rise, most significant bit first
    always @(posedge sck_g) rx_q <= {rx_q[6:0], mosi};
    // Shift on fall; load by bench between frames
    always @(posedge load or negedge sck_g) begin
        if (load) sh_q <= tx_byte;
        else sh_q <= {sh_q[6:0], 1'b0};
    end
    // Sole slave on the bus, so it answers whenever clocked
    assign miso = sh_q[7];
    assign miso_en = sck_en;
endmodule : spp_far_slave

// ===== dv/spp_port_tb.sv
`timescale 1ns/1ps
`include "spp_regs.svh"

module spp_port_tb;
    import spp_pkg::*;

    logic clock, reset_n, cyc, stb, we, ss_r, sck_r, mosi_r, p_ld;
    logic [7:0] adr;
    logic [31:0] dat, rdat;
    spp_byte_t p_tx, p_rx, rx;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_o, ss_oe, routed, p_miso, p_en;
    int fails, num_checks, hi_cnt, hi0;
    wire logic mosi_w = mosi_oe ? mosi_o : mosi_r;
    wire logic miso_w = miso_oe ? miso_o : (p_en ? p_miso : ~miso_o);
    wire logic sck_w = sck_oe ? sck_o : sck_r;
    wire logic ss_w = ss_oe ? ss_o : ss_r;

    spp_port DUT (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe(miso_oe), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .slave_select_line_i(ss_w),
        .slave_select_line_o(ss_o), .slave_select_line_oe(ss_oe), .select_routed(routed));
    spp_far_slave u_far (.sck(sck_o), .sck_en(sck_oe), .mosi(mosi_w), .load(p_ld), .tx_byte(p_tx),
        .miso(p_miso), .miso_en(p_en), .rx_q(p_rx));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and high-phase count to check the divider
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) if (sck_oe && sck_o) hi_cnt <= hi_cnt + 1;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim;
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Classic cycle: hold until ack, release after it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        rdat = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 100) chk("ack", 32'h1, 32'h0);
    endtask : wb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask : rd

    // Poll until the done flag comes up
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            wb(1'b0, `SPP_ADR_CTRL, 32'h0);
            n++;
        end while (rdat[`SPP_BIT_DONE] !== 1'b1 && n < 100);
    endtask : wait_done

    // Bench as external master, 64 ns clock period
    task automatic xfer(input spp_byte_t tx, output spp_byte_t r);
        for (int i = 7; i >= 0; i--) begin
            mosi_r <= tx[i];
            repeat (4) @(posedge clock);
            sck_r <= 1'b1;
            r[i] = miso_w;
            repeat (4) @(posedge clock);
            sck_r <= 1'b0;
        end
    endtask : xfer

    // Master exchange through the far slave
    task automatic mxfer(input spp_byte_t tx, input spp_byte_t back, input int hi);
        p_tx <= back; p_ld <= 1'b1;
        @(posedge clock);
        p_ld <= 1'b0;
        hi0 = hi_cnt;
        wb(1'b1, `SPP_ADR_DATA, {24'h0, tx});
        wait_done;
        chk("far_rx", {24'h0, tx}, {24'h0, p_rx});
        rd("rx", `SPP_ADR_DATA, {24'h0, back});
        chk("sck_high", hi, hi_cnt - hi0);
    endtask : mxfer

    initial begin
        #200000;
        chk("watchdog", 32'h0, 32'h1);
        end_sim;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, sck_r, mosi_r, p_ld, reset_n} = '0;
        {adr, dat, p_tx, fails, num_checks} = '0;
        ss_r = 1'b1;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd("ctrl", `SPP_ADR_CTRL, 32'h04);
        rd("clkdiv", `SPP_ADR_CLKDIV, 32'h03);
        rd("unmapped", 8'h0c, 32'h0);
        chk("routed", 32'h1, 32'(routed));
        // Three-wire master, divider 3
        wb(1'b1, `SPP_ADR_CTRL, 32'h03);
        mxfer(8'h3c, 8'ha5, 32);
        chk("routed", 32'h0, 32'(routed));
        // Select as output, divider 2; the synchronised return needs three cycles per half period
        wb(1'b1, `SPP_ADR_CLKDIV, 32'h02);
        wb(1'b1, `SPP_ADR_CTRL, 32'h0f);
        @(posedge clock);
        chk("ss_out", 32'h3, {30'h0, ss_oe, ss_o});
        wb(1'b1, `SPP_ADR_CTRL, 32'h0b);
        @(posedge clock);
        chk("ss_out", 32'h2, {30'h0, ss_oe, ss_o});
        mxfer(8'hc3, 8'h81, 24);
        // Another master pulls select low; select output high first so no fault comes early
        wb(1'b1, `SPP_ADR_CTRL, 32'h0f);
        wb(1'b1, `SPP_ADR_CTRL, 32'h07);
        rd("ctrl", `SPP_ADR_CTRL, 32'h07);
        ss_r <= 1'b0;
        repeat (6) @(posedge clock);
        rd("ctrl", `SPP_ADR_CTRL, 32'h24);
        chk("mosi_oe", 32'h0, 32'(mosi_oe));
        ss_r <= 1'b1;
        // Four-wire slave: clock ignored while unselected
        wb(1'b1, `SPP_ADR_CTRL, 32'h05);
        wb(1'b1, `SPP_ADR_DATA, 32'h96);
        xfer(8'hff, rx);
        rd("ctrl", `SPP_ADR_CTRL, 32'h05);
        chk("miso_oe", 32'h0, 32'(miso_oe));
        ss_r <= 1'b0;
        repeat (4) @(posedge clock);
        chk("miso_oe", 32'h1, 32'(miso_oe));
        xfer(8'h5a, rx);
        chk("slv_tx", 32'h96, {24'h0, rx});
        repeat (8) @(posedge clock);
        rd("ctrl", `SPP_ADR_CTRL, 32'h85);
        rd("rx", `SPP_ADR_DATA, 32'h5a);
        ss_r <= 1'b1;
        // Three-wire slave always selected
        wb(1'b1, `SPP_ADR_CTRL, 32'h01);
        wb(1'b1, `SPP_ADR_DATA, 32'h69);
        repeat (4) @(posedge clock);
        chk("miso_oe", 32'h1, 32'(miso_oe));
        xfer(8'h12, rx);
        chk("slv_tx", 32'h69, {24'h0, rx});
        repeat (8) @(posedge clock);
        rd("rx", `SPP_ADR_DATA, 32'h12);
        wb(1'b1, `SPP_ADR_CTRL, 32'h00);
        repeat (4) @(posedge clock);
        chk("miso_oe", 32'h0, 32'(miso_oe));
        end_sim;
    end
endmodule : spp_port_tb
